// File: core/rwb_alert_timer.sv
// Radio event alert lead timer
`timescale 1ns/10ps
module rwb_alert_timer #(
  parameter int LEAD_CYC = rwb_pkg::ALERT_LEAD_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  rwb_evt_if.timer ev
);
  initial if (LEAD_CYC < 1 || LEAD_CYC > 65535) $error("LEAD_CYC out of range");

  rwb_pkg::rwb_alert_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic alert_reg, go_reg;

  // Next state: lead phase with alert, then event until its end
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      rwb_pkg::AL_IDLE:
        if (ev.sched && ev.xtal_ok)
        begin
          st_next = rwb_pkg::AL_LEAD;
          cnt_next = 16'(LEAD_CYC - 1);
        end
      rwb_pkg::AL_LEAD:
        if (!ev.xtal_ok)
          st_next = rwb_pkg::AL_IDLE;
        else if (cnt_reg == 16'h0000)
          st_next = rwb_pkg::AL_EVT;
        else
          cnt_next = cnt_reg - 16'h0001;
      rwb_pkg::AL_EVT:
        if (ev.evt_end || !ev.xtal_ok)
          st_next = rwb_pkg::AL_IDLE;
      default:
        st_next = rwb_pkg::AL_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= rwb_pkg::AL_IDLE;
      cnt_reg <= 16'h0000;
      alert_reg <= 1'b0;
      go_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      alert_reg <= (st_next != rwb_pkg::AL_IDLE);
      go_reg <= (st_next == rwb_pkg::AL_EVT);
    end
  end

  assign ev.alert = alert_reg;
  assign ev.go = go_reg;

  AST_GO_NEEDS_XTAL: assert property (@(posedge clk) disable iff (sys_rst)
    go_reg |-> $past(ev.xtal_ok)) else $error("radio active without crystal");
  AST_GO_AFTER_LEAD: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(go_reg) |-> $past(st_reg == rwb_pkg::AL_LEAD && cnt_reg == 16'h0000 && alert_reg))
    else $error("event started without full alert lead");
  AST_ALERT_END: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == rwb_pkg::AL_EVT && ev.evt_end) |=> (!alert_reg && !go_reg))
    else $error("alert not dropped at event end");
endmodule // rwb_alert_timer

// File: core/rwb_evt_if.sv
// Radio event handshake between sequencer and alert timer
`timescale 1ns/10ps
interface rwb_evt_if;
  logic sched;
  logic evt_end;
  logic xtal_ok;
  logic alert;
  logic go;
  modport timer (input sched, input evt_end, input xtal_ok, output alert, output go);
  modport ctrl (output sched, output evt_end, output xtal_ok, input alert, input go);
endinterface

// File: core/rwb_pkg.sv
// Constants and types of the reset, wake-up and boot sequencer
package rwb_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ALERT_LEAD_NS = 18000;
  localparam int ALERT_LEAD_CYC = (ALERT_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_RST_CYC = 4;
  localparam int LOADER_MAX_KBPS = 460;
  // ----------------------------------------------------------------
  // Boot and serial number addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] UPDATER_ADDR = 32'h00000000;
  localparam logic [31:0] STACK_ADDR = 32'h00002000;
  localparam logic [31:0] LOADER_ADDR = 32'h00000000;
  localparam logic [31:0] SN_ADDR_LO = 32'h100007F4;
  localparam logic [31:0] SN_ADDR_HI = 32'h100007F8;
  localparam logic [15:0] SN_PAD = 16'hAA55;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PS_OFF = 5'h01,
    PS_PRE = 5'h02,
    PS_ACT = 5'h04,
    PS_SLEEP = 5'h08,
    PS_STBY = 5'h10
  } rwb_pwr_t;
  typedef enum logic [1:0] {
    BT_STACK = 2'h0,
    BT_UPDATER = 2'h1,
    BT_LOADER = 2'h2
  } rwb_boot_t;
  typedef enum logic [2:0] {
    RC_NONE = 3'h0,
    RC_POR = 3'h1,
    RC_BOR = 3'h2,
    RC_WDOG = 3'h3,
    RC_LOCKUP = 3'h4,
    RC_SYSREQ = 3'h5,
    RC_WAKE = 3'h6
  } rwb_cause_t;
  typedef enum logic [2:0] {
    AL_IDLE = 3'h1,
    AL_LEAD = 3'h2,
    AL_EVT = 3'h4
  } rwb_alert_t;
endpackage

// File: core/rwb_sequencer.sv
// Reset, wake-up, clock start-up and boot selection sequencer
`timescale 1ns/10ps
module rwb_sequencer #(
  parameter int WAKE_CYC = rwb_pkg::WAKE_RST_CYC,
  parameter int LEAD_CYC = rwb_pkg::ALERT_LEAD_CYC,
  parameter logic [47:0] SERIAL = 48'h123456789ABC // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ext_reset_n,
  input wire logic ana_por,
  input wire logic brownout_reset,
  input wire logic ldo_ready,
  input wire logic fast_ring_osc_ready,
  input wire logic main_crystal_osc_ready,
  input wire logic sw_bor_en_wr,
  input wire logic sw_bor_en,
  input wire logic sw_xtal_sel_wr,
  input wire logic sw_xtal_sel,
  input wire logic watchdog_expiry,
  input wire logic sys_reset_req,
  input wire logic cpu_lockup,
  input wire logic sleep_req,
  input wire logic standby_req,
  input wire logic timer_expiry,
  input wire logic host_spi_mode,
  input wire logic spi_cs_n,
  input wire logic radio_event_sched,
  input wire logic radio_event_end,
  input wire logic updater_strap_pin,
  input wire logic loader_strap_pin,
  input wire logic sn_rd_en,
  input wire logic [31:0] sn_rd_addr,
  output rwb_pkg::rwb_pwr_t pwr_state,
  output logic core_rst,
  output logic debug_rst,
  output logic hs_clk_xtal,
  output logic fast_ring_osc_en,
  output logic main_crystal_osc_en,
  output logic bor_en,
  output rwb_pkg::rwb_cause_t reset_cause,
  output rwb_pkg::rwb_boot_t boot_target,
  output logic [31:0] boot_addr,
  output logic radio_event_alert,
  output logic radio_active,
  output logic [31:0] sn_rd_data,
  output logic sn_rd_valid
);
  initial if (WAKE_CYC < 1 || WAKE_CYC > 255) $error("WAKE_CYC out of range");

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rwb_pkg::rwb_pwr_t st_reg, st_next;
  rwb_pkg::rwb_cause_t cause_reg, cause_next;
  rwb_pkg::rwb_boot_t boot_reg, boot_next;
  logic [31:0] baddr_reg, baddr_next;
  logic [7:0] wake_cnt_reg, wake_cnt_next;
  logic bor_en_reg, bor_en_next;
  logic xtal_sel_reg, xtal_sel_next;
  logic por_int_reg;
  logic core_rst_reg, core_rst_next;
  logic xtal_on_reg, ring_en_reg, xtal_en_reg;
  logic por_raw, por_hold, por_rel, wake_src, fault_src, leave_low;
  rwb_evt_if evt ();

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  // Power-on reset merges analog sources and the pin, held for supplies
  assign por_raw = ana_por || (brownout_reset && bor_en_reg) || !ext_reset_n;
  assign por_hold = por_raw || !ldo_ready || !fast_ring_osc_ready;
  assign por_rel = por_int_reg && !por_hold;
  assign fault_src = watchdog_expiry || sys_reset_req || cpu_lockup;
  assign wake_src = timer_expiry || (host_spi_mode && !spi_cs_n);
  assign leave_low = (st_reg == rwb_pkg::PS_SLEEP || st_reg == rwb_pkg::PS_STBY)
    && wake_src && !por_hold;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Next power state
  always_comb
  begin
    st_next = st_reg;
    if (por_hold)
      st_next = rwb_pkg::PS_OFF;
    else
    begin
      unique case (st_reg)
        rwb_pkg::PS_OFF:
          st_next = rwb_pkg::PS_PRE;
        rwb_pkg::PS_PRE:
          if (sleep_req)
            st_next = rwb_pkg::PS_SLEEP;
          else if (standby_req)
            st_next = rwb_pkg::PS_STBY;
          else if (xtal_sel_reg && main_crystal_osc_ready)
            st_next = rwb_pkg::PS_ACT;
        rwb_pkg::PS_ACT:
          if (sleep_req)
            st_next = rwb_pkg::PS_SLEEP;
          else if (standby_req)
            st_next = rwb_pkg::PS_STBY;
          else if (!xtal_sel_reg || !main_crystal_osc_ready)
            st_next = rwb_pkg::PS_PRE;
        rwb_pkg::PS_SLEEP, rwb_pkg::PS_STBY:
          if (wake_src)
            st_next = rwb_pkg::PS_PRE;
        default:
          st_next = rwb_pkg::PS_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core reset and software settings
  // ----------------------------------------------------------------
  // Wake reset counter and core reset level
  always_comb
  begin
    wake_cnt_next = wake_cnt_reg;
    if (leave_low)
      wake_cnt_next = 8'(WAKE_CYC);
    else if (wake_cnt_reg != 8'h00)
      wake_cnt_next = wake_cnt_reg - 8'h01;
    core_rst_next = por_hold || fault_src || (wake_cnt_next != 8'h00);
  end

  // Brown-out enable and crystal selection
  always_comb
  begin
    bor_en_next = bor_en_reg;
    xtal_sel_next = xtal_sel_reg;
    if (ana_por || !ext_reset_n)
      bor_en_next = 1'b1;
    else if (sw_bor_en_wr)
      bor_en_next = sw_bor_en;
    if (core_rst_next)
      xtal_sel_next = 1'b0;
    else if (sw_xtal_sel_wr)
      xtal_sel_next = sw_xtal_sel;
  end

  // Last reset cause, highest priority source wins
  always_comb
  begin
    cause_next = cause_reg;
    if (ana_por || !ext_reset_n)
      cause_next = rwb_pkg::RC_POR;
    else if (brownout_reset && bor_en_reg)
      cause_next = rwb_pkg::RC_BOR;
    else if (watchdog_expiry)
      cause_next = rwb_pkg::RC_WDOG;
    else if (cpu_lockup)
      cause_next = rwb_pkg::RC_LOCKUP;
    else if (sys_reset_req)
      cause_next = rwb_pkg::RC_SYSREQ;
    else if (leave_low)
      cause_next = rwb_pkg::RC_WAKE;
  end

  // ----------------------------------------------------------------
  // Boot selection
  // ----------------------------------------------------------------
  // Straps sampled once as the power-on reset releases
  always_comb
  begin
    boot_next = boot_reg;
    baddr_next = baddr_reg;
    if (por_rel)
    begin
      if (loader_strap_pin)
      begin
        boot_next = rwb_pkg::BT_LOADER;
        baddr_next = rwb_pkg::LOADER_ADDR;
      end
      else if (updater_strap_pin)
      begin
        boot_next = rwb_pkg::BT_UPDATER;
        baddr_next = rwb_pkg::UPDATER_ADDR;
      end
      else
      begin
        boot_next = rwb_pkg::BT_STACK;
        baddr_next = rwb_pkg::STACK_ADDR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // State and output registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_reg <= rwb_pkg::PS_OFF;
      cause_reg <= rwb_pkg::RC_POR;
      boot_reg <= rwb_pkg::BT_STACK;
      baddr_reg <= rwb_pkg::STACK_ADDR;
      wake_cnt_reg <= 8'h00;
      bor_en_reg <= 1'b1;
      xtal_sel_reg <= 1'b0;
      por_int_reg <= 1'b1;
      core_rst_reg <= 1'b1;
      xtal_on_reg <= 1'b0;
      ring_en_reg <= 1'b0;
      xtal_en_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cause_reg <= cause_next;
      boot_reg <= boot_next;
      baddr_reg <= baddr_next;
      wake_cnt_reg <= wake_cnt_next;
      bor_en_reg <= bor_en_next;
      xtal_sel_reg <= xtal_sel_next;
      por_int_reg <= por_hold;
      core_rst_reg <= core_rst_next;
      xtal_on_reg <= (st_next == rwb_pkg::PS_ACT);
      ring_en_reg <= (st_next == rwb_pkg::PS_PRE)
        || (st_next == rwb_pkg::PS_OFF && ext_reset_n);
      xtal_en_reg <= (st_next == rwb_pkg::PS_ACT)
        || (st_next == rwb_pkg::PS_PRE && xtal_sel_next);
    end
  end

  // ----------------------------------------------------------------
  // Submodules and outputs
  // ----------------------------------------------------------------
  // Radio event alert gated on the crystal clock
  assign evt.sched = radio_event_sched;
  assign evt.evt_end = radio_event_end;
  assign evt.xtal_ok = xtal_on_reg;

  rwb_alert_timer #(.LEAD_CYC(LEAD_CYC)) u_alert (
    .clk(clk),
    .sys_rst(sys_rst),
    .ev(evt.timer)
  );

  rwb_sn_rom #(.SERIAL(SERIAL)) u_sn (
    .clk(clk),
    .sys_rst(sys_rst),
    .rd_en(sn_rd_en),
    .rd_addr(sn_rd_addr),
    .rd_data(sn_rd_data),
    .rd_hit(sn_rd_valid)
  );

  // Output assignments
  assign pwr_state = st_reg;
  assign core_rst = core_rst_reg;
  assign debug_rst = por_int_reg;
  assign hs_clk_xtal = xtal_on_reg;
  assign fast_ring_osc_en = ring_en_reg;
  assign main_crystal_osc_en = xtal_en_reg;
  assign bor_en = bor_en_reg;
  assign reset_cause = cause_reg;
  assign boot_target = boot_reg;
  assign boot_addr = baddr_reg;
  assign radio_event_alert = evt.alert;
  assign radio_active = evt.go;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wake;
    leave_low;
  endsequence
  sequence s_wake_done;
    core_rst && pwr_state == rwb_pkg::PS_PRE;
  endsequence

  AST_RING_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(st_reg) == rwb_pkg::PS_OFF && st_reg != rwb_pkg::PS_OFF)
    |-> (st_reg == rwb_pkg::PS_PRE && !hs_clk_xtal))
    else $error("left reset without the ring clock");
  AST_XTAL_NEEDS_SEL: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(hs_clk_xtal) |-> $past(xtal_sel_reg && main_crystal_osc_ready))
    else $error("crystal used before selected and ready");
  AST_WAKE_RST: assert property (@(posedge clk) disable iff (sys_rst)
    s_wake |=> s_wake_done) else $error("wake without core reset");
  AST_FAULT_RST: assert property (@(posedge clk) disable iff (sys_rst)
    fault_src |=> core_rst) else $error("fault did not reset core");
  AST_DEBUG_ISOLATED: assert property (@(posedge clk) disable iff (sys_rst)
    (fault_src || leave_low) && !por_hold |=> !debug_rst)
    else $error("debug reset by core-only source");
  AST_PIN_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    !ext_reset_n |=> (pwr_state == rwb_pkg::PS_OFF && debug_rst && core_rst))
    else $error("reset pin did not power down");
  AST_POR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (!ldo_ready || !fast_ring_osc_ready) |=> debug_rst)
    else $error("power-on reset released early");
  AST_BOR_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> bor_en) else $error("brown-out not enabled after reset");
  AST_CAUSE_WDOG: assert property (@(posedge clk) disable iff (sys_rst)
    (watchdog_expiry && !por_raw) |=> reset_cause == rwb_pkg::RC_WDOG)
    else $error("watchdog cause not recorded");
  AST_BOOT_LOADER: assert property (@(posedge clk) disable iff (sys_rst)
    (por_rel && loader_strap_pin) |=> boot_target == rwb_pkg::BT_LOADER)
    else $error("loader strap ignored");
  AST_BOOT_UPDATER: assert property (@(posedge clk) disable iff (sys_rst)
    (por_rel && !loader_strap_pin && updater_strap_pin)
    |=> (boot_target == rwb_pkg::BT_UPDATER && boot_addr == rwb_pkg::UPDATER_ADDR))
    else $error("updater strap ignored");
  AST_BOOT_STABLE: assert property (@(posedge clk) disable iff (sys_rst)
    !por_rel |=> $stable(boot_target) && $stable(boot_addr))
    else $error("boot choice changed without reset release");
  AST_SLEEP_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == rwb_pkg::PS_SLEEP && timer_expiry && !por_hold)
    |=> pwr_state == rwb_pkg::PS_PRE) else $error("timer did not wake");
endmodule // rwb_sequencer

// File: core/rwb_sn_rom.sv
// Two-word serial number store with registered read
`timescale 1ns/10ps
module rwb_sn_rom #(
  parameter logic [47:0] SERIAL = 48'h123456789ABC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rd_en,
  input wire logic [31:0] rd_addr,
  output logic [31:0] rd_data,
  output logic rd_hit
);
  logic [31:0] data_next;
  logic hit_next;

  // Address decode; unknown addresses read zero without a hit
  always_comb
  begin
    data_next = 32'h00000000;
    hit_next = 1'b0;
    if (rd_en && rd_addr == rwb_pkg::SN_ADDR_LO)
    begin
      data_next = SERIAL[31:0];
      hit_next = 1'b1;
    end
    else if (rd_en && rd_addr == rwb_pkg::SN_ADDR_HI)
    begin
      data_next = {rwb_pkg::SN_PAD, SERIAL[47:32]};
      hit_next = 1'b1;
    end
  end

  // Read register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data <= 32'h00000000;
      rd_hit <= 1'b0;
    end
    else
    begin
      rd_data <= data_next;
      rd_hit <= hit_next;
    end
  end

  AST_SN_PAD: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_en && rd_addr == rwb_pkg::SN_ADDR_HI) |=> (rd_hit && rd_data[31:16] == rwb_pkg::SN_PAD))
    else $error("serial number padding wrong");
endmodule // rwb_sn_rom

// File: verif/rwb_host_model.sv
// Host model driving the reset pin and the two boot straps
`timescale 1ns/10ps
module rwb_host_model #(
  parameter int HOLD_CYC = 1500
) (
  input wire logic clk,
  input wire logic go,
  input wire logic upd_want,
  input wire logic ldr_want,
  output logic ext_reset_n,
  output logic updater_strap_pin,
  output logic loader_strap_pin,
  output logic busy
);
  // Pin held low through supply ramp, then one reset pulse per request
  initial
  begin
    ext_reset_n = 1'b0;
    updater_strap_pin = 1'b0;
    loader_strap_pin = 1'b0;
    busy = 1'b1;
    forever
    begin
      repeat (HOLD_CYC) @(posedge clk);
      ext_reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      // Strap pins move on to other traffic once boot has sampled them
      updater_strap_pin <= !updater_strap_pin;
      loader_strap_pin <= !loader_strap_pin;
      busy <= 1'b0;
      @(posedge clk iff go);
      ext_reset_n <= 1'b0;
      updater_strap_pin <= upd_want;
      loader_strap_pin <= ldr_want;
      busy <= 1'b1;
    end
  end
endmodule // rwb_host_model

// File: verif/tb_reset_wake_boot_sequencer.sv
// Self-checking bench of the reset, wake-up and boot sequencer
`timescale 1ns/10ps
module tb_reset_wake_boot_sequencer;
  localparam int LEAD = 8;
  localparam int WAKE = 4;
  localparam logic [47:0] SER = 48'hA1B2C3D4E5F6; // Arbitrary value
  logic clk, sys_rst, go, upd_want, ldr_want, busy, sn_rd_en, ext_reset_n;
  logic updater_strap_pin, loader_strap_pin, core_rst, debug_rst, hs_clk_xtal, bor_en;
  logic fast_ring_osc_en, main_crystal_osc_en, radio_event_alert, radio_active, sn_rd_valid;
  logic [4:0] pls;
  logic [10:0] lv;
  logic [31:0] sn_rd_addr, boot_addr, sn_rd_data;
  rwb_pkg::rwb_pwr_t pwr_state;
  rwb_pkg::rwb_cause_t reset_cause;
  rwb_pkg::rwb_boot_t boot_target;
  int error_cnt, n_checks, cyc;

  rwb_host_model #(.HOLD_CYC(1500)) HOST (.clk, .go, .upd_want, .ldr_want, .ext_reset_n,
    .updater_strap_pin, .loader_strap_pin, .busy);

  rwb_sequencer #(.WAKE_CYC(WAKE), .LEAD_CYC(LEAD), .SERIAL(SER)) DUT (.clk, .sys_rst,
    .ext_reset_n, .ana_por(lv[4]), .brownout_reset(lv[3]), .ldo_ready(!lv[10]),
    .fast_ring_osc_ready(!lv[10]), .main_crystal_osc_ready(lv[9]), .sw_bor_en_wr(pls[2]),
    .sw_bor_en(1'b0), .sw_xtal_sel_wr(pls[3]), .sw_xtal_sel(1'b1), .watchdog_expiry(lv[0]),
    .sys_reset_req(lv[1]), .cpu_lockup(lv[2]), .sleep_req(lv[5]), .standby_req(lv[6]),
    .timer_expiry(pls[4]), .host_spi_mode(lv[8]), .spi_cs_n(!lv[7]),
    .radio_event_sched(pls[0]), .radio_event_end(pls[1]), .updater_strap_pin,
    .loader_strap_pin, .sn_rd_en, .sn_rd_addr, .pwr_state, .core_rst, .debug_rst,
    .hs_clk_xtal, .fast_ring_osc_en, .main_crystal_osc_en, .bor_en, .reset_cause,
    .boot_target, .boot_addr, .radio_event_alert, .radio_active, .sn_rd_data, .sn_rd_valid);

  // Clock source
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cycle ceiling against a hung run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle pulse; returns just after the edge that takes it
  task automatic pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls[b] <= 1'b0;
    #1;
  endtask

  task automatic setlv(input int b, input logic v);
    @(posedge clk);
    lv[b] <= v;
    tick(1);
  endtask

  task automatic t_boot(input logic upd, input logic ldr, input logic first);
    if (!first)
    begin
      @(posedge clk);
      {upd_want, ldr_want, go} <= {upd, ldr, 1'b1};
      @(posedge clk);
      go <= 1'b0;
      tick(2);
      chk(debug_rst, 1'b1);
      chk(core_rst, 1'b1);
      chk(pwr_state, rwb_pkg::PS_OFF);
    end
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) tick(1);
    tick(2);
    chk(debug_rst, 1'b0);
    chk(pwr_state, rwb_pkg::PS_PRE);
    chk(fast_ring_osc_en, 1'b1);
    chk(hs_clk_xtal, 1'b0);
    chk(bor_en, 1'b1);
    chk(reset_cause, rwb_pkg::RC_POR);
    chk(boot_target, ldr ? rwb_pkg::BT_LOADER : upd ? rwb_pkg::BT_UPDATER : rwb_pkg::BT_STACK);
    chk(boot_addr, (ldr || upd) ? 32'h00000000 : 32'h00002000);
    $display("end boot");
  endtask

  task automatic t_xtal;
    pulse(0);
    tick(2);
    chk(radio_event_alert, 1'b0);
    pulse(3);
    chk(main_crystal_osc_en, 1'b1);
    tick(3);
    chk(hs_clk_xtal, 1'b0);
    chk(fast_ring_osc_en, 1'b1);
    setlv(9, 1'b1);
    chk(pwr_state, rwb_pkg::PS_ACT);
    chk(hs_clk_xtal, 1'b1);
    chk(fast_ring_osc_en, 1'b0);
    $display("end xtal");
  endtask

  task automatic t_alert;
    int n = 0;
    pulse(0);
    for (int i = 0; i < LEAD + 3; i++)
    begin
      n += (radio_event_alert === 1'b1 && radio_active === 1'b0);
      tick(1);
    end
    chk_cnt(n, LEAD);
    chk(radio_active, 1'b1);
    pulse(1);
    chk({radio_event_alert, radio_active}, 2'h0);
    pulse(0);
    tick(2);
    chk(radio_event_alert, 1'b1);
    setlv(9, 1'b0);
    chk(pwr_state, rwb_pkg::PS_PRE);
    chk(hs_clk_xtal, 1'b0);
    tick(1);
    chk(radio_event_alert, 1'b0);
    setlv(9, 1'b1);
    chk(pwr_state, rwb_pkg::PS_ACT);
    $display("end alert");
  endtask

  task automatic t_sleep;
    int n = 0;
    setlv(5, 1'b1);
    chk(pwr_state, rwb_pkg::PS_SLEEP);
    chk(main_crystal_osc_en, 1'b0);
    setlv(5, 1'b0);
    pulse(4);
    chk(pwr_state, rwb_pkg::PS_PRE);
    chk(reset_cause, rwb_pkg::RC_WAKE);
    for (int i = 0; i < 8; i++)
    begin
      n += (core_rst === 1'b1);
      tick(1);
    end
    chk_cnt(n, WAKE);
    chk(debug_rst, 1'b0);
    chk(hs_clk_xtal, 1'b0);
    setlv(6, 1'b1);
    setlv(6, 1'b0);
    setlv(7, 1'b1);
    chk(pwr_state, rwb_pkg::PS_STBY);
    setlv(7, 1'b0);
    setlv(8, 1'b1);
    setlv(7, 1'b1);
    tick(1);
    chk(pwr_state, rwb_pkg::PS_PRE);
    setlv(7, 1'b0);
    $display("end sleep");
  endtask

  task automatic t_fault;
    rwb_pkg::rwb_cause_t exp[5] = '{rwb_pkg::RC_WDOG, rwb_pkg::RC_SYSREQ,
      rwb_pkg::RC_LOCKUP, rwb_pkg::RC_BOR, rwb_pkg::RC_POR};
    for (int b = 0; b < 5; b++)
    begin
      setlv(b, 1'b1);
      chk(reset_cause, exp[b]);
      chk(core_rst, 1'b1);
      chk(debug_rst, b > 2);
      setlv(b, 1'b0);
      tick(3);
      chk(core_rst, 1'b0);
    end
    setlv(10, 1'b1);
    chk(debug_rst, 1'b1);
    chk(pwr_state, rwb_pkg::PS_OFF);
    chk(fast_ring_osc_en, 1'b1);
    setlv(10, 1'b0);
    chk(debug_rst, 1'b0);
    pulse(2);
    chk(bor_en, 1'b0);
    setlv(3, 1'b1);
    chk(debug_rst, 1'b0);
    setlv(3, 1'b0);
    $display("end fault");
  endtask

  task automatic t_sn;
    logic [31:0] a[3] = '{32'h100007F4, 32'h100007F8, 32'h100007FC};
    logic [31:0] d[3] = '{SER[31:0], {16'hAA55, SER[47:32]}, 32'h00000000};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      sn_rd_en <= (i < 3);
      sn_rd_addr <= a[i % 3];
      if (i > 0)
      begin
        #1;
        chk(sn_rd_data, d[i - 1]);
        chk(sn_rd_valid, i < 3);
      end
    end
    $display("end serial");
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {go, upd_want, ldr_want, sn_rd_en} = 4'h0;
    pls = '0;
    lv = '0;
    sn_rd_addr = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) t_boot(k[0], k[1], k == 0);
    t_xtal();
    t_alert();
    t_sleep();
    t_fault();
    t_sn();
    test_done();
  end
endmodule // tb_reset_wake_boot_sequencer
